/* hw/dob_pkg.sv */
package dob_pkg;

   // Array widths
   localparam int ROW_W  = 14;
   localparam int BA_W   = 3;
   localparam int COL_W  = 11;
   localparam int ADDR_W = 14;

   // Row bit dropped for the sixteen-bit organisation
   localparam int ROW_X16_MSB = 13;

   // Device organisation
   typedef enum logic [1:0] {
      DOB_ORG_X4  = 2'h0,
      DOB_ORG_X8  = 2'h1,
      DOB_ORG_X16 = 2'h2
   } dob_org_t;

   // Power state reported by the command logic
   typedef enum logic [1:0] {
      DOB_PWR_ACTIVE = 2'h0,
      DOB_PWR_ACT_PD = 2'h1,
      DOB_PWR_PRE_PD = 2'h2,
      DOB_PWR_SREF   = 2'h3
   } dob_pwr_t;

   // Termination value field {A6,A2}; zero disables termination
   localparam logic [1:0] RTT_OFF = 2'h0;

   // Column-to-column spacing in clocks
   localparam logic [2:0] TCCD_BL4 = 3'h2;
   localparam logic [2:0] TCCD_BL8 = 3'h4;
   localparam logic [2:0] CCD_MAX  = 3'h7;

   // Last beat pair of a burst
   localparam logic [1:0] BEAT_LAST_BL4 = 2'h1;
   localparam logic [1:0] BEAT_LAST_BL8 = 2'h3;

   // Synchronous termination delay in clocks after sampling
   localparam int ODT_DLY_CK = 2;

   // Depth of the column latency line
   localparam int LAT_DEPTH = 16;

   // Mode settings carried into the link domain
   typedef struct packed {
      dob_org_t   org;
      logic       dqsc_dis;
      logic       rdqs_en;
      logic [1:0] rtt;
      logic       intlv;
      logic       bl8;
      logic [2:0] al;
      logic [2:0] cl;
      logic       dll_off;
      logic       sref;
   } dob_cfg_t;

endpackage : dob_pkg

/* hw/dob_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module dob_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data crossing in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } dob_sync_state_t;

   dob_sync_state_t r;
   dob_sync_state_t n;

   // Two-flop chain; only stage2 is read
   always_comb begin
      n        = r;
      n.stage1 = d;
      n.stage2 = r.stage1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.stage2;

endmodule : dob_sync

`default_nettype wire

/* hw/dob_core.sv */
`timescale 1ns/1ns
`default_nettype none

module dob_core #(
   parameter int ODT_DLY = dob_pkg::ODT_DLY_CK,
   parameter int LAT_D   = dob_pkg::LAT_DEPTH
) (
   // Clocks and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       clk_ck,
   // Mode settings, system clock
   input  wire logic [1:0]                 org,
   input  wire logic                       emr_dqsc_dis,
   input  wire logic                       emr_rdqs_en,
   input  wire logic [1:0]                 emr_rtt,
   input  wire logic                       mr_slow_exit,
   input  wire logic [1:0]                 pwr_state,
   input  wire logic                       burst_intlv,
   input  wire logic                       burst_len8,
   input  wire logic [2:0]                 add_lat,
   input  wire logic [2:0]                 cas_lat,
   // Command pins, link clock
   input  wire logic                       cs_n,
   input  wire logic                       ras_n,
   input  wire logic                       cas_n,
   input  wire logic                       we_n,
   input  wire logic [dob_pkg::BA_W-1:0]   ba,
   input  wire logic [dob_pkg::ADDR_W-1:0] addr,
   input  wire logic                       odt,
   // Termination controls, link clock
   output logic                            term_dq,
   output logic                            term_dqs,
   output logic                            term_dqs_c,
   output logic                            term_udqs_c,
   output logic                            term_dm,
   output logic                            term_rdqs,
   output logic                            term_rdqs_c,
   output logic [1:0]                      rtt_sel,
   // Command results, link clock
   output logic                            act_pulse,
   output logic [dob_pkg::BA_W-1:0]        act_bank,
   output logic [dob_pkg::ROW_W-1:0]       act_row,
   output logic                            burst_valid,
   output logic                            burst_write,
   output logic [dob_pkg::COL_W-1:0]       col_even,
   output logic [dob_pkg::COL_W-1:0]       col_odd,
   // Events and status, system clock
   output logic                            act_evt,
   output logic                            col_evt,
   output logic                            ccd_err_evt,
   output logic                            odt_async
);

   localparam int CW = dob_pkg::COL_W;

   // Elaboration checks
   if (ODT_DLY < 1 || ODT_DLY > 3) begin : g_chk_dly
      $error("ODT_DLY must be 1 to 3");
   end
   if (LAT_D < 12 || LAT_D > 16) begin : g_chk_lat
      $error("LAT_D must be 12 to 16");
   end

   // Link domain state
   typedef struct packed {
      logic [ODT_DLY-1:0]        odt_line;
      logic                      term_dq;
      logic                      term_dqs;
      logic                      term_dqs_c;
      logic                      term_udqs_c;
      logic                      term_dm;
      logic                      term_rdqs;
      logic                      term_rdqs_c;
      logic [1:0]                rtt_sel;
      logic                      act_pulse;
      logic [dob_pkg::BA_W-1:0]  act_bank;
      logic [dob_pkg::ROW_W-1:0] act_row;
      logic [LAT_D-1:0]          lat_v;
      logic [LAT_D-1:0]          lat_w;
      logic [LAT_D-1:0][CW-1:0]  lat_c;
      logic                      burst_valid;
      logic                      burst_write;
      logic [CW-1:0]             col_even;
      logic [CW-1:0]             col_odd;
      logic                      b_active;
      logic [CW-1:0]             b_start;
      logic [1:0]                b_beat;
      logic [2:0]                ccd_cnt;
      logic                      col_seen;
      logic [2:0]                tog;
   } dob_link_t;

   // System domain state
   typedef struct packed {
      dob_pkg::dob_cfg_t cfg;
      logic [2:0]        tog_prev;
      logic              act_evt;
      logic              col_evt;
      logic              err_evt;
      logic              odt_async;
   } dob_sys_t;

   dob_link_t         lr;
   dob_link_t         ln;
   dob_sys_t          sr;
   dob_sys_t          sn;
   dob_pkg::dob_cfg_t c;
   logic [15:0]       cfg_q;
   logic [2:0]        tog_q;
   logic              is_act;
   logic              is_col;
   logic              cond_sync;
   logic              cond_async;

   // Column of beat i within the aligned burst segment
   function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] s,
                                               input logic [2:0]    i,
                                               input logic          intlv,
                                               input logic          bl8);
      logic [1:0] lo;
      logic       hi;
      lo = intlv ? (s[1:0] ^ i[1:0]) : 2'(s[1:0] + i[1:0]);
      hi = bl8 ? (s[2] ^ i[2]) : s[2];
      burst_col = {s[CW-1:3], hi, lo};
   endfunction : burst_col

   // Mode settings into the link domain; changed only while idle
   dob_sync #(.W(16)) u_cfg_sync (
      .clk   (clk_ck),
      .rst_n (rst_n),
      .d     (sr.cfg),
      .q     (cfg_q)
   );

   // Event toggles back into the system domain
   dob_sync #(.W(3)) u_evt_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (lr.tog),
      .q     (tog_q)
   );

   assign c = dob_pkg::dob_cfg_t'(cfg_q);

   // Command decode at the rising link edge
   assign is_act = !cs_n && !ras_n && cas_n && we_n;
   assign is_col = !cs_n && ras_n && !cas_n;

   // System side: mode bundle, timing mode, event pulses
   always_comb begin
      sn              = sr;
      sn.cfg.org      = dob_pkg::dob_org_t'(org);
      sn.cfg.dqsc_dis = emr_dqsc_dis;
      sn.cfg.rdqs_en  = emr_rdqs_en;
      sn.cfg.rtt      = emr_rtt;
      sn.cfg.intlv    = burst_intlv;
      sn.cfg.bl8      = burst_len8;
      sn.cfg.al       = add_lat;
      sn.cfg.cl       = cas_lat;
      sn.cfg.dll_off  = (pwr_state == dob_pkg::DOB_PWR_PRE_PD) ||
                        (pwr_state == dob_pkg::DOB_PWR_ACT_PD && mr_slow_exit);
      sn.cfg.sref     = (pwr_state == dob_pkg::DOB_PWR_SREF);
      sn.odt_async    = sn.cfg.dll_off;
      sn.tog_prev     = tog_q;
      sn.act_evt      = tog_q[0] ^ sr.tog_prev[0];
      sn.col_evt      = tog_q[1] ^ sr.tog_prev[1];
      sn.err_evt      = tog_q[2] ^ sr.tog_prev[2];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sr <= '0;
      end else begin
         sr <= sn;
      end
   end

   // Link side: termination, activate capture, column latency, bursts
   always_comb begin
      logic       on;
      logic       x8;
      logic       x16;
      logic [3:0] rl;
      logic [3:0] lat;
      logic [3:0] slot;
      logic [2:0] tccd;
      logic [1:0] last;
      on   = 1'b0;
      x8   = (c.org == dob_pkg::DOB_ORG_X8);
      x16  = (c.org == dob_pkg::DOB_ORG_X16);
      rl   = 4'(c.al) + 4'(c.cl);
      lat  = (is_col && !we_n) ? 4'(rl - 4'h1) : rl;
      slot = (lat == 4'h0) ? 4'h0 : 4'(lat - 4'h1);
      tccd = c.bl8 ? dob_pkg::TCCD_BL8 : dob_pkg::TCCD_BL4;
      last = c.bl8 ? dob_pkg::BEAT_LAST_BL8 : dob_pkg::BEAT_LAST_BL4;
      ln             = lr;
      ln.act_pulse   = 1'b0;
      ln.burst_valid = 1'b0;

      // Termination pin sampled every edge, delayed in synchronous mode
      ln.odt_line[0] = odt;
      for (int i = 1; i < ODT_DLY; i++) begin
         ln.odt_line[i] = lr.odt_line[i-1];
      end
      on = c.dll_off ? lr.odt_line[0] : lr.odt_line[ODT_DLY-1];
      on = on && (c.rtt != dob_pkg::RTT_OFF) && !c.sref;
      ln.term_dq     = on;
      ln.term_dqs    = on;
      ln.term_dqs_c  = on && !c.dqsc_dis;
      ln.term_udqs_c = on && !c.dqsc_dis && x16;
      ln.term_dm     = on && !(x8 && c.rdqs_en);
      ln.term_rdqs   = on && x8 && c.rdqs_en;
      ln.term_rdqs_c = on && x8 && c.rdqs_en && !c.dqsc_dis;
      ln.rtt_sel     = c.sref ? dob_pkg::RTT_OFF : c.rtt;

      // Activate: bank and row capture
      if (is_act) begin
         ln.act_pulse = 1'b1;
         ln.act_bank  = ba;
         ln.act_row   = addr;
         if (x16) begin
            ln.act_row[dob_pkg::ROW_X16_MSB] = 1'b0;
         end
         ln.tog[0] = ~lr.tog[0];
      end

      // Latency line advances one slot per clock
      for (int i = 0; i < LAT_D - 1; i++) begin
         ln.lat_v[i] = lr.lat_v[i+1];
         ln.lat_w[i] = lr.lat_w[i+1];
         ln.lat_c[i] = lr.lat_c[i+1];
      end
      ln.lat_v[LAT_D-1] = 1'b0;

      // Column command: spacing check and posting by its latency
      if (is_col) begin
         ln.tog[1] = ~lr.tog[1];
         if (lr.col_seen && lr.ccd_cnt < tccd) begin
            ln.tog[2] = ~lr.tog[2];
         end
         ln.ccd_cnt     = 3'h1;
         ln.col_seen    = 1'b1;
         ln.lat_v[slot] = 1'b1;
         ln.lat_w[slot] = !we_n;
         ln.lat_c[slot] = {addr[11], addr[9:0]};
      end else if (lr.ccd_cnt != dob_pkg::CCD_MAX) begin
         ln.ccd_cnt = 3'(lr.ccd_cnt + 3'h1);
      end

      // Burst beats, two columns per clock; a new start cuts in
      if (lr.lat_v[0]) begin
         ln.burst_valid = 1'b1;
         ln.burst_write = lr.lat_w[0];
         ln.b_start     = lr.lat_c[0];
         ln.col_even    = burst_col(lr.lat_c[0], 3'h0, c.intlv, c.bl8);
         ln.col_odd     = burst_col(lr.lat_c[0], 3'h1, c.intlv, c.bl8);
         ln.b_beat      = 2'h1;
         ln.b_active    = 1'b1;
      end else if (lr.b_active) begin
         ln.burst_valid = 1'b1;
         ln.col_even    = burst_col(lr.b_start, {lr.b_beat, 1'b0}, c.intlv, c.bl8);
         ln.col_odd     = burst_col(lr.b_start, {lr.b_beat, 1'b1}, c.intlv, c.bl8);
         ln.b_beat      = 2'(lr.b_beat + 2'h1);
         ln.b_active    = (lr.b_beat != last);
      end
   end

   always_ff @(posedge clk_ck or negedge rst_n) begin
      if (!rst_n) begin
         lr <= '0;
      end else begin
         lr <= ln;
      end
   end

   // Outputs straight from flops
   assign term_dq     = lr.term_dq;
   assign term_dqs    = lr.term_dqs;
   assign term_dqs_c  = lr.term_dqs_c;
   assign term_udqs_c = lr.term_udqs_c;
   assign term_dm     = lr.term_dm;
   assign term_rdqs   = lr.term_rdqs;
   assign term_rdqs_c = lr.term_rdqs_c;
   assign rtt_sel     = lr.rtt_sel;
   assign act_pulse   = lr.act_pulse;
   assign act_bank    = lr.act_bank;
   assign act_row     = lr.act_row;
   assign burst_valid = lr.burst_valid;
   assign burst_write = lr.burst_write;
   assign col_even    = lr.col_even;
   assign col_odd     = lr.col_odd;
   assign act_evt     = sr.act_evt;
   assign col_evt     = sr.col_evt;
   assign ccd_err_evt = sr.err_evt;
   assign odt_async   = sr.odt_async;

   // Helper terms for the checks
   assign cond_sync  = (c.rtt != dob_pkg::RTT_OFF) && !c.sref && !c.dll_off;
   assign cond_async = (c.rtt != dob_pkg::RTT_OFF) && !c.sref && c.dll_off;

   // Checks on the link side
   sref_off_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      c.sref |=> !term_dq && !term_dqs && rtt_sel == dob_pkg::RTT_OFF)
      else $error("termination active in self-refresh");
   rtt_off_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      c.rtt == dob_pkg::RTT_OFF |=> !term_dq && !term_dm && !term_rdqs)
      else $error("termination active while disabled");
   rtt_pick_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      !c.sref |=> rtt_sel == $past(c.rtt))
      else $error("wrong termination value selected");
   shared_pin_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      term_dm |-> !term_rdqs && !($past(c.org) == dob_pkg::DOB_ORG_X8 && $past(c.rdqs_en)))
      else $error("shared pin terminated as mask in read strobe mode");
   dqs_comp_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      term_dqs_c |-> term_dqs && !$past(c.dqsc_dis))
      else $error("complement strobe terminated while disabled");
   rdqs_comp_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      term_rdqs_c |-> $past(c.org) == dob_pkg::DOB_ORG_X8 && $past(c.rdqs_en)
                      && !$past(c.dqsc_dis))
      else $error("read strobe complement terminated wrongly");
   upper_comp_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      term_udqs_c |-> term_dqs_c && $past(c.org) == dob_pkg::DOB_ORG_X16)
      else $error("upper complement strobe outside sixteen-bit mode");
   odt_sync_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      cond_sync [*4] |-> term_dq == $past(odt, ODT_DLY + 1))
      else $error("synchronous termination delay wrong");
   odt_async_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      cond_async [*2] |-> term_dq == $past(odt, 2))
      else $error("asynchronous termination delay wrong");
   act_cap_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      is_act |=> act_pulse && act_bank == $past(ba))
      else $error("activate bank not captured");
   row_x16_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      is_act && c.org == dob_pkg::DOB_ORG_X16 |=> !act_row[dob_pkg::ROW_X16_MSB])
      else $error("sixteen-bit row uses top address bit");
   col_lat_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      is_col && !we_n |-> ##[1:15] burst_valid && burst_write)
      else $error("write burst did not start");
   seg_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      burst_valid |-> col_even[CW-1:3] == col_odd[CW-1:3]
                      && (c.bl8 || col_even[2] == col_odd[2]))
      else $error("burst left its segment");
   ccd_a: assert property (@(posedge clk_ck) disable iff (!rst_n)
      is_col && lr.col_seen && lr.ccd_cnt < (c.bl8 ? dob_pkg::TCCD_BL8 : dob_pkg::TCCD_BL4)
      |=> lr.tog[2] != $past(lr.tog[2]))
      else $error("column spacing error not flagged");

   // Main scenarios
   act_c: cover property (@(posedge clk_ck) disable iff (!rst_n) act_pulse);
   burst8_c: cover property (@(posedge clk_ck) disable iff (!rst_n)
      burst_valid && c.bl8 [*4]);
   term_c: cover property (@(posedge clk_ck) disable iff (!rst_n) cond_async && term_dq);
   err_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ccd_err_evt);

endmodule : dob_core

`default_nettype wire

/* test/dob_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none

module dob_ctrl_model (
   // Memory clock
   input  wire logic   clk_ck,
   // Command pins
   output logic        cs_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [2:0]  ba,
   output logic [13:0] addr,
   // Termination request
   output logic        odt
);
   // Deselected and quiet at start
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ba = 3'h0;
      addr = 14'h0000;
      odt = 1'b0;
   end

   // One command, held across its sampling edge
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
      {cs_n, ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      @(posedge clk_ck);
      #1;
   endtask : issue

   // Deselect; ba and addr are inverted, ras_n, cas_n and we_n keep their old value
   task automatic rest();
      cs_n = 1'b1;
      ba = ~ba;
      addr = ~addr;
   endtask : rest

   // Termination request level
   task automatic term(input logic v);
      odt = v;
   endtask : term
endmodule : dob_ctrl_model

`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
   localparam int ODT_D = 2;

   // Clocks, reset and mode settings
   logic       clk_sys = 1'b0;
   logic       clk_ck = 1'b0;
   logic       rst_n = 1'b0;
   logic [1:0] org = 2'h0;
   logic [1:0] emr_rtt = 2'h1;
   logic [1:0] pwr_state = 2'h0;
   logic [2:0] add_lat = 3'h0;
   logic [2:0] cas_lat = 3'h3;
   logic       emr_dqsc_dis = 1'b0;
   logic       emr_rdqs_en = 1'b0;
   logic       mr_slow_exit = 1'b0;
   logic       burst_intlv = 1'b0;
   logic       burst_len8 = 1'b0;
   // Link pins and design outputs
   logic        cs_n, ras_n, cas_n, we_n, odt, act_pulse, burst_valid, burst_write;
   logic        term_dq, term_dqs, term_dqs_c, term_udqs_c, term_dm, term_rdqs, term_rdqs_c;
   logic        act_evt, col_evt, ccd_err_evt, odt_async;
   logic [1:0]  rtt_sel;
   logic [2:0]  ba, act_bank;
   logic [13:0] addr, act_row;
   logic [10:0] col_even, col_odd;
   logic [6:0]  term_v;
   int          failures = 0;
   int          samples_checked = 0;
   int          act_cnt = 0;
   int          ccd_cnt = 0;
   int          col_cnt = 0;

   assign term_v = {term_dq, term_dqs, term_dqs_c, term_udqs_c, term_dm, term_rdqs, term_rdqs_c};

   // System clock and free-running memory clock
   always #5 clk_sys = ~clk_sys;
   always begin
      #8 clk_ck = 1'b1;
      #7 clk_ck = 1'b0;
   end

   dob_ctrl_model u_ctrl (.clk_ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt);
   dob_core #(.ODT_DLY(ODT_D), .LAT_D(16)) dut (
      .clk_sys, .rst_n, .clk_ck, .org, .emr_dqsc_dis, .emr_rdqs_en, .emr_rtt, .mr_slow_exit,
      .pwr_state, .burst_intlv, .burst_len8, .add_lat, .cas_lat, .cs_n, .ras_n, .cas_n,
      .we_n, .ba, .addr, .odt, .term_dq, .term_dqs, .term_dqs_c, .term_udqs_c, .term_dm,
      .term_rdqs, .term_rdqs_c, .rtt_sel, .act_pulse, .act_bank, .act_row, .burst_valid,
      .burst_write, .col_even, .col_odd, .act_evt, .col_evt, .ccd_err_evt, .odt_async);

   // Event counters
   always @(posedge clk_sys) begin
      if (act_evt === 1'b1) act_cnt++;
      if (ccd_err_evt === 1'b1) ccd_cnt++;
      if (col_evt === 1'b1) col_cnt++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic ck(input int n);
      repeat (n) @(posedge clk_ck);
      #1;
   endtask : ck

   task automatic sys1();
      @(posedge clk_sys);
      #1;
   endtask : sys1

   task automatic stop_test();
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Expected terminated pins for the present mode
   function automatic logic [6:0] exp_term();
      logic rd;
      rd = (org == 2'h1) && emr_rdqs_en;
      if (emr_rtt == 2'h0 || pwr_state == 2'h3) return 7'h00;
      return {2'b11, !emr_dqsc_dis, org == 2'h2 && !emr_dqsc_dis, !rd, rd, rd && !emr_dqsc_dis};
   endfunction : exp_term

   // Column of beat i within the aligned segment
   function automatic logic [10:0] bcol(input logic [10:0] s, input logic [2:0] i);
      if (burst_intlv) return {s[10:3], s[2:0] ^ i};
      return {s[10:3], s[2] ^ i[2], s[1:0] + i[1:0]};
   endfunction : bcol

   // Raise termination request, check exact switch edge, then drop it
   task automatic odt_step(input int d);
      u_ctrl.term(1'b1);
      ck(d);
      chk(32'(term_v), 0);
      ck(1);
      chk(32'(term_v), 32'(exp_term()));
      chk(32'(rtt_sel), 32'(exp_term() == 7'h00 ? 2'h0 : emr_rtt));
      u_ctrl.term(1'b0);
      ck(d + 2);
      chk(32'(term_v), 0);
   endtask : odt_step

   // Column command to bank 1, then latency and beat order
   task automatic burst(input logic w, input logic [10:0] s);
      int n;
      int lat;
      lat = int'(add_lat) + int'(cas_lat) - int'(w);
      n = 0;
      u_ctrl.issue({3'b010, !w}, 3'h1, {2'h0, s[10], 1'b1, s[9:0]});
      u_ctrl.rest();
      while (burst_valid !== 1'b1 && n < 40) begin
         ck(1);
         n++;
      end
      chk(n, lat);
      for (int p = 0; p < (burst_len8 ? 4 : 2); p++) begin
         chk({burst_write, col_even, col_odd}, {w, bcol(s, 3'(2 * p)), bcol(s, 3'(2 * p + 1))});
         ck(1);
      end
      chk(32'(burst_valid), 0);
      ck(6);
   endtask : burst

   // Two reads g clocks apart; e says whether a spacing fault is flagged
   task automatic ccd(input int g, input logic e);
      int c0;
      c0 = ccd_cnt;
      u_ctrl.issue(4'h5, 3'h1, 14'h0000);
      if (g > 1) begin
         u_ctrl.rest();
         ck(g - 1);
      end
      u_ctrl.issue(4'h5, 3'h1, 14'h0008);
      u_ctrl.rest();
      ck(30);
      chk(32'(ccd_cnt != c0), 32'(e));
   endtask : ccd

   // Watchdog
   initial begin
      #900000;
      failures++;
      stop_test();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      ck(6);
      for (int i = 0; i < 12; i++) begin
         sys1();
         org = 2'(i / 4);
         emr_dqsc_dis = i[0];
         emr_rdqs_en = i[1];
         emr_rtt = 2'(i % 3 + 1);
         ck(8);
         odt_step(ODT_D);
      end
      sys1();
      emr_rtt = 2'h0;
      ck(8);
      odt_step(ODT_D);
      sys1();
      emr_rtt = 2'h2;
      pwr_state = 2'h3;
      ck(8);
      odt_step(ODT_D);
      for (int j = 0; j < 4; j++) begin
         sys1();
         pwr_state = 2'(j - j / 2);
         mr_slow_exit = (j == 2);
         ck(8);
         chk(32'(odt_async), 32'(j >= 2));
         odt_step(j >= 2 ? 1 : ODT_D);
      end
      $display("termination tests done");
      sys1();
      pwr_state = 2'h0;
      for (int i = 0; i < 2; i++) begin
         sys1();
         org = 2'(i + 1);
         ck(8);
         u_ctrl.issue(4'h3, 3'(4 + i), 14'h3FFF);
         u_ctrl.rest();
         chk({act_pulse, act_bank, act_row}, {1'b1, 3'(4 + i), i ? 14'h1FFF : 14'h3FFF});
         ck(1);
         chk(32'(act_pulse), 0);
      end
      ck(20);
      chk(act_cnt, 2);
      $display("activate tests done");
      for (int i = 0; i < 4; i++) begin
         sys1();
         burst_len8 = i[1];
         burst_intlv = i[0];
         add_lat = 3'(i + i / 3);
         cas_lat = 3'(3 + i / 2);
         ck(8);
         if (i == 0) u_ctrl.issue(4'h3, 3'h1, 14'h0123);
         burst(i[0], 11'(12'h401 + 3 * i));
      end
      ck(10);
      chk(col_cnt, 4);
      for (int i = 0; i < 4; i++) begin
         sys1();
         burst_len8 = i[1];
         ck(8);
         ccd(i[0] ? (i[1] ? 4 : 2) : (i[1] ? 2 : 1), !i[0]);
      end
      $display("column tests done");
      stop_test();
   end
endmodule : tb

`default_nettype wire
